// File: hdl/sai_top.v
/*
 * Status and alarm indicator block of a power module: command checking,
 * fan duty register, user and customer byte storage, lamps and
 * monitoring outputs, sticky alarms and an alert output.
 * Assumes an Avalon-MM master on i_clk_sys and raw condition pins that
 * are asynchronous to it. Every access takes one wait state, so the
 * master sees waitrequest low on the second edge of its request.
 * The thermal loop supplies its cooling demand on the same clock, so
 * that bus is used without synchronising.
 * Lamp codes and monitor levels are plain levels; the pin drivers and
 * the lamp current limits sit outside this block.
 */
// How it works
// - Bad command or data sets alarm, alert
// - Unsupported command reads back zero
// - Fan duty 0..100, 100 means 16000 RPM
// - Fan held at least minimum cooling need
// - Ninety-six user bytes over the bus
// - 128 customer bytes, write-protect blocks writes
// - Red fault lamp means fault state
// - Normal: green lamps, all outputs high
// - Input lost: lamps off, red, three low
// - Overtemperature: thermal good low too
// - Clear faults resets; persisting faults reassert
`timescale 1ns/1ns
`default_nettype none
`include "sai_regs.vh"
module sai_top (
  input wire i_clk_sys,
  input wire i_rst,
  // Avalon-MM slave, word addressed
  input wire [3:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output wire o_avs_waitrequest,
  // Raw condition inputs from the power stage
  input wire i_input_low,
  input wire i_overvoltage_shutdown,
  input wire i_overcurrent,
  input wire i_overtemp,
  input wire i_write_protect,
  // Cooling demand from the thermal loop, percent
  input wire [7:0] i_fan_need,
  // Lamps: bit1 green, bit0 red
  output reg [1:0] o_input_lamp,
  output reg [1:0] o_output_good_lamp,
  output reg [1:0] o_fault_lamp,
  // Monitoring outputs, high means good
  output reg o_fault_n,
  output reg o_output_good,
  output reg o_input_good,
  output reg o_temp_good,
  // Fan drive duty, percent
  output reg [7:0] o_fan_duty,
  // Alert output, active low level
  output wire o_alert_n,
  output wire o_irq
);
  // Condition pins come straight from the power stage and may move at
  // any time, so each one is filtered before any output or alarm sees it.
  // The filter needs two agreeing samples, which also rejects a one-cycle
  // glitch that sneaks past the first flip-flop.
  // Three-stage synchronisers for the five condition pins
  reg [4:0] sync1, sync2, sync3;
  // Filtered condition levels
  reg [4:0] cond;
  wire [4:0] raw = {i_write_protect, i_overtemp, i_overcurrent,
                    i_overvoltage_shutdown, i_input_low};

  // Sync chain; a change counts once stage two and three agree
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
      sync3 <= 5'h00;
      cond <= 5'h00;
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
      sync3 <= sync2;
      cond <= (sync2 & sync3) | (cond & (sync2 | sync3));
    end
  end

  // Named views of the filtered condition bits, in pin order
  wire c_in_low = cond[0];
  wire c_ov = cond[1];
  wire c_oc = cond[2];
  wire c_ot = cond[3];
  wire c_wp = cond[4];

  // All lamps and monitors are registered from the same filtered levels, so
  // they change together on one edge and never show a mixed state.
  // Reset shows every monitor low: the host cannot read a good module while
  // reset is held; the first edge after it loads them from the still-cleared filter.
  // Registered lamps and monitoring outputs
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_input_lamp <= `SAI_LAMP_OFF;
      o_output_good_lamp <= `SAI_LAMP_OFF;
      o_fault_lamp <= `SAI_LAMP_OFF;
      o_fault_n <= 1'b0;
      o_output_good <= 1'b0;
      o_input_good <= 1'b0;
      o_temp_good <= 1'b0;
    end else begin
      // Input lamp green unless input lost
      o_input_lamp <= c_in_low ? `SAI_LAMP_OFF : `SAI_LAMP_GREEN;
      // Any fault turns output lamp off, fault lamp red
      o_output_good_lamp <= (c_in_low | c_ov | c_oc | c_ot) ?
                            `SAI_LAMP_OFF : `SAI_LAMP_GREEN;
      o_fault_lamp <= (c_in_low | c_ov | c_oc | c_ot) ?
                      `SAI_LAMP_RED : `SAI_LAMP_OFF;
      // Monitoring levels combine all active faults
      o_fault_n <= ~(c_in_low | c_ov | c_oc | c_ot);
      o_output_good <= ~(c_in_low | c_ov | c_oc | c_ot);
      // Input good tracks the input alone
      o_input_good <= ~c_in_low;
      // Only overtemperature drops thermal good
      o_temp_good <= ~c_ot;
    end
  end

  // The wait state gives the read mux a cycle to settle into the readdata
  // register and lets the byte store answer from its own output register.
  // A write acts on the first edge of the request; the second edge only
  // closes the handshake, so ack blocks a second action.
  // Bus handshake: one wait cycle for every access so reads come from flops
  reg ack;
  wire req = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~ack;
  wire wr_go = i_avs_write & ~ack;
  wire rd_go = i_avs_read & ~ack;

  // Status is sticky and write-one-to-clear; mask has the same layout and
  // only gates the alert, never the status bits themselves.
  // Registers steered by software
  reg [`SAI_STAT_W-1:0] status;
  reg [`SAI_STAT_W-1:0] mask;
  reg [7:0] fan_set;
  reg [7:0] fan_min;
  reg [7:0] mem_addr;
  reg [7:0] last_cmd;
  reg clear_pend;

  wire [7:0] wb = i_avs_writedata[7:0];
  wire lane0 = i_avs_byteenable[0];
  wire cmd_wr = wr_go & lane0 & (i_avs_address == `SAI_A_CMD);
  // Command recognised or not
  wire cmd_known = (wb == `SAI_CMD_CLEAR) | (wb == `SAI_CMD_FAN) |
                   (wb == `SAI_CMD_MEM);
  wire fan_wr = wr_go & lane0 & (i_avs_address == `SAI_A_FAN);
  wire fan_bad = fan_wr & (wb > `SAI_FAN_MAX);
  wire mem_wr = wr_go & lane0 & (i_avs_address == `SAI_A_MEM_DATA);
  wire addr_bad = (mem_addr >= `SAI_MEM_END);
  wire cust_area = (mem_addr >= `SAI_CUST_BASE);
  // Customer writes blocked by protect
  wire wp_block = mem_wr & cust_area & c_wp & ~addr_bad;
  wire mem_we = mem_wr & ~addr_bad & ~(cust_area & c_wp);
  wire [7:0] mem_q;

  // Condition bits feed status every cycle, so a live fault keeps its bit
  // set even while software writes a one to clear it.
  // Status events, set wins over clear
  wire [`SAI_STAT_W-1:0] ev;
  assign ev[`SAI_B_CMD_BAD] = cmd_wr & ~cmd_known;
  assign ev[`SAI_B_DATA_BAD] = fan_bad | (mem_wr & addr_bad);
  assign ev[`SAI_B_IN_LOW] = c_in_low;
  assign ev[`SAI_B_OV] = c_ov;
  assign ev[`SAI_B_OC] = c_oc;
  assign ev[`SAI_B_OT] = c_ot;
  assign ev[`SAI_B_WP_BLOCK] = wp_block;

  wire stat_w1c = wr_go & lane0 & (i_avs_address == `SAI_A_STATUS);

  // Status, mask, fan, memory pointer and clear-faults handling
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ack <= 1'b0;
      status <= {`SAI_STAT_W{1'b0}};
      mask <= {`SAI_STAT_W{1'b0}};
      fan_set <= 8'h00;
      fan_min <= 8'h00;
      mem_addr <= 8'h00;
      last_cmd <= 8'h00;
      clear_pend <= 1'b0;
    end else begin
      // Ack marks the second edge of an access
      ack <= req & ~ack;
      // Clear-faults loads status with live faults only, on the same edge
      if (cmd_wr & (wb == `SAI_CMD_CLEAR)) begin
        status <= ev;
        clear_pend <= 1'b1;
      end else begin
        // Sticky set beats write-one clear
        status <= (status & ~(stat_w1c ? wb[`SAI_STAT_W-1:0] : 7'h00)) | ev;
        clear_pend <= 1'b0;
      end
      // Last command is kept for read back, good or bad
      if (cmd_wr) begin
        last_cmd <= wb;
      end
      // Mask takes the low lane only
      if (wr_go & lane0 & (i_avs_address == `SAI_A_MASK)) begin
        mask <= wb[`SAI_STAT_W-1:0];
      end
      // Out-of-range duty is rejected, old value kept
      if (fan_wr & ~fan_bad) begin
        fan_set <= wb;
      end
      // Floor beyond full scale is ignored
      if (wr_go & lane0 & (i_avs_address == `SAI_A_FAN_MIN) &
          (wb <= `SAI_FAN_MAX)) begin
        fan_min <= wb;
      end
      // Pointer moves on every stored or read byte, so a burst needs
      // only one address write
      if (wr_go & lane0 & (i_avs_address == `SAI_A_MEM_ADDR)) begin
        mem_addr <= wb;
      end else if ((mem_wr & ~addr_bad) | (rd_go &
                   (i_avs_address == `SAI_A_MEM_DATA))) begin
        mem_addr <= mem_addr + 8'h01;
      end
    end
  end

  // The duty is the largest of the host setting, the host floor and the
  // clamped thermal demand, so software can raise the fan but never starve
  // the module of cooling.
  // Fan duty never below cooling need or floor
  wire [7:0] need = (i_fan_need > `SAI_FAN_MAX) ? `SAI_FAN_MAX : i_fan_need;
  wire [7:0] floor_v = (need > fan_min) ? need : fan_min;
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_fan_duty <= 8'h00;
    end else begin
      o_fan_duty <= (fan_set > floor_v) ? fan_set : floor_v;
    end
  end

  // Estimated fan rate: duty x 16000 / 100
  // Full duty times full rate needs 21 bits; the quotient fits 16 bits
  wire [23:0] rpm_prod = o_fan_duty * `SAI_FAN_FULL_RPM;
  wire [23:0] rpm_quot = rpm_prod / {16'h0000, `SAI_FAN_MAX};
  wire [15:0] rpm = rpm_quot[15:0];

  // One array holds both areas; the customer area starts right after the
  // user bytes. Index checks and write protection are done here, so the
  // store itself stays a plain array with registered read data.
  // Shared byte store: user area then customer area
  sai_mem #(
    .DEPTH(`SAI_USER_BYTES + `SAI_CUST_BYTES)
  ) u_mem (
    .i_clk_sys(i_clk_sys),
    .i_we(mem_we),
    .i_addr(mem_addr),
    .i_wdata(wb),
    .o_rdata(mem_q)
  );

  // Reads decode the address combinationally and the result is held in
  // readdata from the first edge of the request until the next read.
  // Read mux, registered on the wait cycle
  reg [31:0] next_rdata;
  always @* begin
    next_rdata = `SAI_ZERO32;
    case (i_avs_address)
      `SAI_A_STATUS: next_rdata = {25'h0, status};
      `SAI_A_MASK: next_rdata = {25'h0, mask};
      `SAI_A_COND: next_rdata = {27'h0, cond};
      // Bad last command reads zero
      `SAI_A_CMD: next_rdata = status[`SAI_B_CMD_BAD] ? `SAI_ZERO32 :
                               {24'h0, last_cmd};
      `SAI_A_FAN: next_rdata = {24'h0, o_fan_duty};
      `SAI_A_FAN_RPM: next_rdata = {16'h0, rpm};
      `SAI_A_FAN_MIN: next_rdata = {24'h0, fan_min};
      `SAI_A_LAMPS: next_rdata = {22'h0, o_temp_good, o_input_good,
                                  o_output_good, o_fault_n, o_input_lamp,
                                  o_output_good_lamp, o_fault_lamp};
      `SAI_A_MEM_ADDR: next_rdata = {24'h0, mem_addr};
      `SAI_A_MEM_DATA: next_rdata = addr_bad ? `SAI_ZERO32 : {24'h0, mem_q};
      `SAI_A_MEM_CTRL: next_rdata = {30'h0, clear_pend, c_wp};
      default: next_rdata = `SAI_ZERO32; // Unmapped reads zero
    endcase
  end

  // Read data register, loaded only on the first edge of a read
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_avs_readdata <= `SAI_ZERO32;
    end else if (rd_go) begin
      o_avs_readdata <= next_rdata;
    end
  end

  // The alert is a plain level: it drops as soon as every unmasked status
  // bit is cleared and rises again on the next live fault.
  // Alert from any unmasked sticky bit
  assign o_irq = |(status & mask);
  assign o_alert_n = ~o_irq;
endmodule
`default_nettype wire

// File: hdl/sai_regs.vh
/*
 * Register offsets, field positions, command codes, fan scale, memory
 * sizes and lamp codes of the status and alarm indicator block.
 * Assumes inclusion by its bare name from the design and bench files.
 */
`ifndef SAI_REGS_VH
`define SAI_REGS_VH

// Word addresses on the Avalon bus (byte address = 4 x word)
`define SAI_A_STATUS      4'h0
`define SAI_A_MASK        4'h1
`define SAI_A_COND        4'h2
`define SAI_A_CMD         4'h3
`define SAI_A_FAN         4'h4
`define SAI_A_FAN_RPM     4'h5
`define SAI_A_FAN_MIN     4'h6
`define SAI_A_LAMPS       4'h7
`define SAI_A_MEM_ADDR    4'h8
`define SAI_A_MEM_DATA    4'h9
`define SAI_A_MEM_CTRL    4'hA

// Status / mask bit positions
`define SAI_B_CMD_BAD     0
`define SAI_B_DATA_BAD    1
`define SAI_B_IN_LOW      2
`define SAI_B_OV          3
`define SAI_B_OC          4
`define SAI_B_OT          5
`define SAI_B_WP_BLOCK    6
`define SAI_STAT_W        7

// Clear-faults command code and supported command codes
`define SAI_CMD_CLEAR     8'h03
`define SAI_CMD_FAN       8'hD7
`define SAI_CMD_MEM       8'hB0

// Fan scale
`define SAI_FAN_MAX       8'h64
`define SAI_FAN_FULL_RPM  16'h3E80

// Memory sizes
`define SAI_USER_BYTES    96
`define SAI_CUST_BYTES    128
`define SAI_MEM_AW        8
`define SAI_CUST_BASE     8'h60
`define SAI_MEM_END       8'hE0

// Lamp codes: bit1 green, bit0 red
`define SAI_LAMP_OFF      2'h0
`define SAI_LAMP_RED      2'h1
`define SAI_LAMP_GREEN    2'h2

`define SAI_ZERO32        32'h0000_0000
`endif

// File: hdl/sai_mem.v
/*
 * Nonvolatile storage model: one byte array holding the user area and
 * the customer area back to back, read data from a register.
 * Assumes the caller checks address range and write protection.
 */
`timescale 1ns/1ns
`default_nettype none
`include "sai_regs.vh"
module sai_mem #(
  parameter DEPTH = 224
) (
  input wire i_clk_sys,
  input wire i_we,
  input wire [`SAI_MEM_AW-1:0] i_addr,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata
);
  // Byte storage
  reg [7:0] mem [0:DEPTH-1];

  // Write port and registered read
  always @(posedge i_clk_sys) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end
endmodule
`default_nettype wire

// File: tb/sai_host.sv
/* Avalon-MM host model driving sai_top.
   Assumes each transfer starts just after a rising edge. */
`timescale 1ns/1ns
`default_nettype none
module sai_host (
  input wire logic i_clk_sys,
  input wire logic i_wait,
  input wire logic [31:0] i_rdata,
  output logic [3:0] o_addr,
  output logic o_rd,
  output logic o_wr,
  output logic [31:0] o_wdata
);
  // Idle bus from time zero
  initial begin
    o_rd = 0;
    o_wr = 0;
    o_addr = 0;
    o_wdata = 0;
  end
  // Hold request until waitrequest is seen low, then release and skip an edge
  task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d,
                      output logic [31:0] q);
    o_addr <= a;
    o_wdata <= {24'h0, d};
    o_wr <= w;
    o_rd <= !w;
    @(posedge i_clk_sys);
    while (i_wait) @(posedge i_clk_sys);
    q = i_rdata;
    o_wr <= 0;
    o_rd <= 0;
    @(posedge i_clk_sys);
  endtask
endmodule
`default_nettype wire

// File: tb/sai_assertions.sv
/* Port checks of sai_top.
   Assumes one clock domain and binding into every sai_top. */
`timescale 1ns/1ns
`default_nettype none
`include "sai_regs.vh"
module sai_chk (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic i_overtemp,
  input wire logic [7:0] i_fan_need,
  input wire logic [1:0] o_input_lamp,
  input wire logic [1:0] o_output_good_lamp,
  input wire logic [1:0] o_fault_lamp,
  input wire logic o_fault_n,
  input wire logic o_output_good,
  input wire logic o_input_good,
  input wire logic o_temp_good,
  input wire logic [7:0] o_fan_duty,
  input wire logic o_alert_n,
  input wire logic o_irq
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // Pending bus request, over-temperature held, demand held in range
  sequence req_wait; (i_avs_read || i_avs_write) && o_avs_waitrequest; endsequence
  sequence hot_held; i_overtemp [*7]; endsequence
  sequence need_held; ($stable(i_fan_need) && i_fan_need <= 8'h64) [*3]; endsequence
  alert_tracks_a: assert property (o_alert_n == !o_irq)
    else $error("alert not inverse of irq");
  one_wait_a: assert property (req_wait |=> !o_avs_waitrequest)
    else $error("wait state too long");
  red_fault_a: assert property (o_fault_lamp == `SAI_LAMP_RED |->
    !o_fault_n && !o_output_good && o_output_good_lamp == `SAI_LAMP_OFF) else $error("red lamp");
  normal_lamps_a: assert property (o_fault_n |-> o_fault_lamp == `SAI_LAMP_OFF &&
    o_output_good_lamp == `SAI_LAMP_GREEN) else $error("normal lamps");
  input_lamp_a: assert property (o_input_lamp == (o_input_good ? 2'h2 : 2'h0))
    else $error("input lamp");
  temp_fault_a: assert property (!o_temp_good |-> !o_fault_n)
    else $error("temp without fault");
  hot_trip_a: assert property (hot_held |-> !o_temp_good)
    else $error("overtemp not shown");
  duty_cap_a: assert property (o_fan_duty <= 8'h64)
    else $error("duty above full scale");
  duty_floor_a: assert property (need_held |-> o_fan_duty >= i_fan_need)
    else $error("duty below need");
endmodule
bind sai_top sai_chk chk_u (.i_clk_sys, .i_rst, .i_avs_read, .i_avs_write,
  .o_avs_waitrequest, .i_overtemp, .i_fan_need, .o_input_lamp, .o_output_good_lamp,
  .o_fault_lamp, .o_fault_n, .o_output_good, .o_input_good, .o_temp_good,
  .o_fan_duty, .o_alert_n, .o_irq);
`default_nettype wire

// File: tb/status_alarm_indicator_tb.sv
/* Self-checking bench of sai_top with host model and reference model.
   Assumes sai_host and sai_chk compiled before it. */
`timescale 1ns/1ns
`default_nettype none
`include "sai_regs.vh"
module status_alarm_indicator_tb;
  logic clk = 0, rst = 1, wp = 0; // Clock, reset, write protect
  logic [3:0] cnd = 0; // Overtemp, overcurrent, overvoltage, input low
  logic [7:0] need = 0; // Cooling demand
  logic [31:0] q; // Last read word
  logic [31:0] lf = 32'h48567997; // Random generator state
  int err_total = 0, tests_run = 0, cyc = 0, st = 0, s, d, m;
  wire logic [3:0] a;
  wire logic rd, wr, wt, fn, og, ig, tg, al, irq;
  wire logic [31:0] wd, rdat;
  wire logic [1:0] l_in, l_out, l_flt;
  wire logic [7:0] duty;
  sai_host host_u (.i_clk_sys(clk), .i_wait(wt), .i_rdata(rdat), .o_addr(a),
    .o_rd(rd), .o_wr(wr), .o_wdata(wd));
  sai_top dut_u (.i_clk_sys(clk), .i_rst(rst), .i_avs_address(a), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wt), .i_input_low(cnd[0]),
    .i_overvoltage_shutdown(cnd[1]), .i_overcurrent(cnd[2]), .i_overtemp(cnd[3]),
    .i_write_protect(wp), .i_fan_need(need), .o_input_lamp(l_in),
    .o_output_good_lamp(l_out), .o_fault_lamp(l_flt), .o_fault_n(fn),
    .o_output_good(og), .o_input_good(ig), .o_temp_good(tg), .o_fan_duty(duty),
    .o_alert_n(al), .o_irq(irq));
  always #5 clk = ~clk;
  // Hang guard: whole run is well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      err_total++;
      end_of_test();
    end
  end
  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction
  // Expected lamps and monitors for a set of live conditions
  function automatic logic [9:0] mon(input logic [3:0] c);
    logic f;
    f = |c;
    return {c[0] ? 2'h0 : 2'h2, f ? 2'h0 : 2'h2, f ? 2'h1 : 2'h0, !f, !f, !c[0], !c[3]};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr_b(input logic [3:0] ad, input logic [7:0] dt);
    host_u.xfer(1, ad, dt, q);
  endtask
  task automatic rd_c(input logic [3:0] ad, input logic [31:0] e);
    host_u.xfer(0, ad, 8'h00, q);
    chk(q, e);
  endtask
  task automatic end_of_test();
    if (err_total == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    wr_b(`SAI_A_MASK, 8'h7F);
    // Every combination of conditions, sticky status accumulates
    for (int i = 0; i < 16; i++) begin
      cnd <= i[3:0];
      repeat (8) @(posedge clk);
      st |= i << 2;
      chk({l_in, l_out, l_flt, fn, og, ig, tg}, mon(i[3:0]));
      chk(irq, st != 0);
      rd_c(`SAI_A_STATUS, 8'(st));
    end
    cnd <= 4'h1;
    repeat (8) @(posedge clk);
    wr_b(`SAI_A_CMD, `SAI_CMD_CLEAR);
    rd_c(`SAI_A_STATUS, 8'h04);
    chk(irq, 1);
    cnd <= 4'h0;
    repeat (8) @(posedge clk);
    wr_b(`SAI_A_STATUS, 8'h04);
    chk({irq, al}, 2'b01);
    wr_b(`SAI_A_CMD, 8'h55);
    rd_c(`SAI_A_CMD, 8'h00);
    chk({irq, al}, 2'b10);
    rd_c(`SAI_A_STATUS, 8'h01);
    wr_b(`SAI_A_MASK, 8'h00);
    chk(irq, 0);
    rd_c(4'hF, 8'h00);
    wr_b(`SAI_A_FAN_MIN, 8'h00);
    wr_b(`SAI_A_FAN, 8'h65);
    // Random duty settings against random demand, first at full scale
    for (int i = 0; i < 6; i++) begin
      s = (i == 0) ? 100 : rnd() % 101;
      d = rnd() % 128;
      m = (d > 100) ? 100 : d;
      need <= d[7:0];
      wr_b(`SAI_A_FAN, 8'(s));
      repeat (3) @(posedge clk);
      chk(duty, (s > m) ? s : m);
      rd_c(`SAI_A_FAN_RPM, ((s > m) ? s : m) * 16000 / 100);
    end
    wr_b(`SAI_A_MEM_ADDR, 8'h5F);
    wr_b(`SAI_A_MEM_DATA, 8'hA5);
    wr_b(`SAI_A_MEM_DATA, 8'h3C);
    wp <= 1;
    repeat (8) @(posedge clk);
    wr_b(`SAI_A_MEM_ADDR, 8'h60);
    wr_b(`SAI_A_MEM_DATA, 8'hC3);
    wr_b(`SAI_A_MEM_ADDR, 8'h5F);
    rd_c(`SAI_A_MEM_DATA, 8'hA5);
    rd_c(`SAI_A_MEM_DATA, 8'h3C);
    wr_b(`SAI_A_MEM_ADDR, 8'hE0);
    wr_b(`SAI_A_MEM_DATA, 8'h11);
    rd_c(`SAI_A_STATUS, 8'h43);
    end_of_test();
  end
endmodule
`default_nettype wire
